// file: src/ats_pkg.sv
/*
 * Package for the acquisition trigger sequencer: register map, field
 * positions, reset values, sequencer states and the frame strobe bundle.
 * Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave port.
 */
`default_nettype none
package ats_pkg;
    // Byte addresses of the word registers
    localparam logic [7:0] ATS_CTRL_ADDR = 8'h00;
    localparam logic [7:0] ATS_COUNT_ADDR = 8'h04;
    localparam logic [7:0] ATS_PERIOD_ADDR = 8'h08;
    localparam logic [7:0] ATS_STATUS_ADDR = 8'h0c;
    localparam logic [7:0] ATS_CMD_ADDR = 8'h10;
    localparam logic [7:0] ATS_DONE_ADDR = 8'h14;

    // Control fields
    localparam int ATS_ACQ_MODE_BIT = 0;
    localparam int ATS_ACQ_SRC_BIT = 1;
    localparam int ATS_FRM_MODE_BIT = 2;
    localparam int ATS_FRM_SRC_BIT = 3;
    localparam int ATS_RATE_EN_BIT = 4;
    localparam int ATS_LINE_IN_BIT = 5;
    localparam int ATS_RUN_BIT = 6;
    localparam int ATS_CTRL_W = 7;
    localparam logic [ATS_CTRL_W-1:0] ATS_CTRL_RST = 7'h00;

    // Source encodings: line 1 or software command
    localparam logic ATS_SRC_LINE1 = 1'b0;
    localparam logic ATS_SRC_SOFT = 1'b1;

    // Command bits, write one to execute
    localparam int ATS_CMD_ACQ_BIT = 0;
    localparam int ATS_CMD_FRM_BIT = 1;

    localparam int ATS_CNT_W = 16;
    localparam int ATS_PER_W = 24;
    localparam logic [ATS_CNT_W-1:0] ATS_COUNT_RST = 16'h0001;
    localparam logic [ATS_PER_W-1:0] ATS_PERIOD_RST = 24'h000000;
    // Fastest internal frame start spacing in cycles when pacing is off
    localparam logic [ATS_PER_W-1:0] ATS_MIN_PERIOD = 24'h000002;

    // Status fields
    localparam int ATS_ST_WAIT_ACQ_BIT = 0;
    localparam int ATS_ST_WAIT_FRM_BIT = 1;

    typedef enum {
        ATS_IDLE,
        ATS_WAIT_ACQ,
        ATS_WAIT_FRM
    } ats_state_e;

    typedef struct packed {
        logic frame_start;
        logic [ATS_CNT_W-1:0] frame_index;
    } ats_frame_s;
endpackage
`default_nettype wire

// file: src/ats_pacer.sv
/*
 * Internal frame start pulse generator.
 * Assumes period is held stable by software; a pulse every period cycles.
 */
`default_nettype none
module ats_pacer
    import ats_pkg::*;
#(
    parameter int PER_W = ATS_PER_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic [PER_W-1:0] period,
    output logic pulse
);
    logic [PER_W-1:0] count;
    logic [PER_W-1:0] next_count;
    wire logic wrap = (count >= period - PER_W'(1));

    assign next_count = (!run || wrap) ? '0 : count + PER_W'(1);
    assign pulse = run && wrap;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// file: src/ats_sequencer.sv
/*
 * Acquisition trigger sequencer: two trigger levels gate frame starts.
 * Assumes a classic Wishbone master on clk_sys and an asynchronous line 1 pin.
 */
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`default_nettype none
module ats_sequencer
    import ats_pkg::*;
#(
    parameter int CNT_W = ATS_CNT_W,
    parameter int PER_W = ATS_PER_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line1_in,
    output ats_frame_s frame_o,
    output logic acquiring
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [ATS_CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] burst_count;
    logic [PER_W-1:0] frame_period;
    logic [CNT_W-1:0] frames_done;
    ats_state_e state;
    ats_state_e next_state;
    logic ack;
    logic [31:0] rdata;
    logic cmd_acq;
    logic cmd_frm;

    wire logic bus_req = wb_cyc_i && wb_stb_i && !ack;
    wire logic bus_wr = bus_req && wb_we_i;
    wire logic sel_lo = wb_sel_i[0];
    wire logic sel_hi = wb_sel_i[1];
    wire logic sel_b2 = wb_sel_i[2];
    wire logic wr_ctrl = bus_wr && (wb_adr_i == ATS_CTRL_ADDR) && sel_lo;
    wire logic wr_count = bus_wr && (wb_adr_i == ATS_COUNT_ADDR);
    wire logic wr_period = bus_wr && (wb_adr_i == ATS_PERIOD_ADDR);
    wire logic wr_cmd = bus_wr && (wb_adr_i == ATS_CMD_ADDR) && sel_lo;

    wire logic acq_mode = ctrl[ATS_ACQ_MODE_BIT];
    wire logic acq_src = ctrl[ATS_ACQ_SRC_BIT];
    wire logic frm_mode = ctrl[ATS_FRM_MODE_BIT];
    wire logic frm_src = ctrl[ATS_FRM_SRC_BIT];
    wire logic rate_en = ctrl[ATS_RATE_EN_BIT];
    wire logic line_is_in = ctrl[ATS_LINE_IN_BIT];
    wire logic run = ctrl[ATS_RUN_BIT];

    function automatic logic [7:0] pick_byte(input logic sel, input logic [7:0] old_v,
                                             input logic [7:0] new_v);
        pick_byte = sel ? new_v : old_v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Line 1 synchroniser and edge detect
    logic line_meta;
    logic line_sync;
    logic line_prev;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_meta <= 1'b0;
            line_sync <= 1'b0;
            line_prev <= 1'b0;
        end else begin
            line_meta <= line1_in;
            line_sync <= line_meta;
            line_prev <= line_sync;
        end
    end

    wire logic line_rise = line_is_in && line_sync && !line_prev;

    ////////////////////////////////////////////////////////////////////
    // Trigger selection
    // software acquisition command or line 1 rise, by source
    wire logic acq_user = (acq_src == ATS_SRC_SOFT) ? cmd_acq : line_rise;
    // line or software acquisition start, internal start when off
    wire logic acq_event = acq_mode ? acq_user : 1'b1;

    wire logic [PER_W-1:0] pace_period =
        (rate_en && frame_period > ATS_MIN_PERIOD) ? frame_period : ATS_MIN_PERIOD;
    wire logic pace_pulse;

    ats_pacer #(
        .PER_W(PER_W)
    ) u_pacer (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(run),
        .period(pace_period),
        .pulse(pace_pulse)
    );

    // software or line frame start, one event per frame
    wire logic frm_user = (frm_src == ATS_SRC_SOFT) ? cmd_frm : line_rise;
    // internal frame starts, free run when both off
    wire logic frm_event = frm_mode ? frm_user : pace_pulse;

    // frame start only while waiting for frame start
    wire logic frame_take = (state == ATS_WAIT_FRM) && frm_event;
    wire logic [CNT_W-1:0] frames_next = frames_done + CNT_W'(1);
    wire logic burst_end = frame_take && (frames_next >= burst_count);

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ATS_IDLE: begin
                if (run) begin
                    next_state = ATS_WAIT_ACQ;
                end
            end
            ATS_WAIT_ACQ: begin
                // leave to idle when run clears, else on an acquisition start
                if (!run) begin
                    next_state = ATS_IDLE;
                end else if (acq_event) begin
                    next_state = ATS_WAIT_FRM;
                end
            end
            ATS_WAIT_FRM: begin
                if (!run) begin
                    next_state = ATS_IDLE;
                end else if (burst_end) begin
                    next_state = ATS_WAIT_ACQ;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ATS_IDLE;
            frames_done <= '0;
            frame_o <= '0;
        end else begin
            state <= next_state;
            frame_o.frame_start <= frame_take;
            if (frame_take) begin
                frame_o.frame_index <= frames_done;
            end
            // clear counter on acquisition start, count frames
            if (state == ATS_WAIT_ACQ && next_state == ATS_WAIT_FRM) begin
                frames_done <= '0;
            end else if (frame_take) begin
                frames_done <= frames_next;
            end
        end
    end

    assign acquiring = (state == ATS_WAIT_FRM);

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave
    wire logic [31:0] status_word = {30'h00000000, state == ATS_WAIT_FRM,
                                     state == ATS_WAIT_ACQ};

    always_comb begin
        unique case (wb_adr_i)
            ATS_CTRL_ADDR: rdata = {25'h0, ctrl};
            ATS_COUNT_ADDR: rdata = {16'h0000, 16'(burst_count)};
            ATS_PERIOD_ADDR: rdata = {8'h00, 24'(frame_period)};
            ATS_STATUS_ADDR: rdata = status_word;
            ATS_DONE_ADDR: rdata = {16'h0000, 16'(frames_done)};
            default: rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl <= ATS_CTRL_RST;
            burst_count <= ATS_COUNT_RST;
            frame_period <= ATS_PERIOD_RST;
            cmd_acq <= 1'b0;
            cmd_frm <= 1'b0;
        end else begin
            ack <= bus_req;
            if (bus_req) begin
                wb_dat_o <= rdata;
            end
            if (wr_ctrl) begin
                ctrl <= wb_dat_i[ATS_CTRL_W-1:0];
            end
            if (wr_count) begin
                burst_count[7:0] <= pick_byte(sel_lo, burst_count[7:0], wb_dat_i[7:0]);
                burst_count[15:8] <= pick_byte(sel_hi, burst_count[15:8], wb_dat_i[15:8]);
            end
            if (wr_period) begin
                frame_period[7:0] <= pick_byte(sel_lo, frame_period[7:0], wb_dat_i[7:0]);
                frame_period[15:8] <= pick_byte(sel_hi, frame_period[15:8],
                                                wb_dat_i[15:8]);
                frame_period[23:16] <= pick_byte(sel_b2, frame_period[23:16],
                                                 wb_dat_i[23:16]);
            end
            cmd_acq <= wr_cmd && wb_dat_i[ATS_CMD_ACQ_BIT];
            cmd_frm <= wr_cmd && wb_dat_i[ATS_CMD_FRM_BIT];
        end
    end

    assign wb_ack_o = ack;
endmodule
`default_nettype wire

// file: test/ats_sva.sv
/* Port checker for ats_sequencer. Assumes it is bound to that module. */
`default_nettype none
module ats_sva
    import ats_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire ats_frame_s frame_o,
    input wire logic acquiring
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ATS_CNT_W-1:0] ei;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_fs;
        frame_o.frame_start;
    endsequence
    // Expected index of the next frame; a burst's last strobe lands in the cycle acquiring falls
    always_ff @(posedge clk_sys) begin
        if (rst || !acquiring) begin
            ei <= '0;
        end else if (frame_o.frame_start) begin
            ei <= ei + 16'h0001;
        end
    end
    ////////////////////////////////////////
    a_ack_answer: assert property (s_req |=> wb_ack_o)
        else $error("ack late");
    a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack unasked");
    a_frame_in_acq: assert property (s_fs |-> $past(acquiring))
        else $error("frame outside burst");
    a_frame_index: assert property (s_fs |-> frame_o.frame_index == ei)
        else $error("frame index wrong");
    a_burst_end: assert property (
        $fell(acquiring) |-> frame_o.frame_start || $past(wb_ack_o && wb_we_i))
        else $error("burst ended early");
    a_idx_hold: assert property ($changed(frame_o.frame_index) |-> s_fs)
        else $error("index moved");
    a_frame_gap: assert property (s_fs |=> !frame_o.frame_start)
        else $error("frames too close");
endmodule
bind ats_sequencer ats_sva chk_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .frame_o(frame_o),
    .acquiring(acquiring));
`default_nettype wire

// file: test/ats_line_src.sv
/* Far-side sensor on line 1. Assumes fire is a one-cycle request. */
`default_nettype none
module ats_line_src (
    input wire logic clk_sys,
    input wire logic fire,
    output logic line1_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold = 2'h0;
    initial line1_in = 1'b0;
    always @(posedge clk_sys) begin
        if (fire) begin
            line1_in <= 1'b1;
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else begin
            line1_in <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: test/ats_sequencer_tb.sv
/* Testbench for ats_sequencer. Assumes the checker and line model compile first. */
`default_nettype none
module ats_sequencer_tb;
    import ats_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0, rd, wb_dat_o;
    logic wb_ack_o, line1_in, acquiring;
    ats_frame_s frame_o;
    int num_errors = 0, n_compared = 0, nfr = 0, cn = 0, last = 0, gap = 0, per, n0;
    ats_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .line1_in(line1_in), .frame_o(frame_o), .acquiring(acquiring));
    ats_line_src line_u (.clk_sys(clk_sys), .fire(fire), .line1_in(line1_in));
    always #20 clk_sys = ~clk_sys;
    task wrap_up;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cn++;
        if (cn > 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    always @(negedge clk_sys) if (frame_o.frame_start === 1'b1) begin
        nfr++;
        gap = cn - last;
        last = cn;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk({31'h0, wb_ack_o}, 32'h1);
    endtask
    task automatic pulse;
        @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask
    task automatic wait_acq(input logic v);
        int n;
        n = 0;
        while (acquiring !== v && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk({31'h0, acquiring}, {31'h0, v});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(56));
        per = 3 + $urandom % 6;
        idle(3);
        rst <= 1'b0;
        wb(0, ATS_CTRL_ADDR, 0);
        chk(rd, 32'h0);
        wb(0, ATS_COUNT_ADDR, 0);
        chk(rd, {16'h0, ATS_COUNT_RST});
        wb(0, 8'h18, 0);
        chk(rd, 32'h0);
        wb(1, ATS_COUNT_ADDR, 32'h3);
        wb(1, ATS_PERIOD_ADDR, per);
        wb(1, ATS_CTRL_ADDR, 32'h71);
        idle(20);
        wb(0, ATS_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        chk(nfr, 0);
        pulse();
        wait_acq(1);
        wait_acq(0);
        chk(nfr, 3);
        chk(gap, per);
        wb(0, ATS_DONE_ADDR, 0);
        chk(rd, 32'h3);
        idle(40);
        chk(nfr, 3);
        pulse();
        wait_acq(1);
        wait_acq(0);
        chk(nfr, 6);
        // Software start, frames from line 1
        wb(1, ATS_COUNT_ADDR, 32'h2);
        wb(1, ATS_CTRL_ADDR, 32'h67);
        n0 = nfr;
        pulse();
        idle(10);
        chk(nfr - n0, 0);
        wb(1, ATS_CMD_ADDR, 32'h1);
        wait_acq(1);
        wb(0, ATS_STATUS_ADDR, 0);
        chk(rd, 32'h2);
        repeat (3) begin
            pulse();
            idle(10);
        end
        chk(nfr - n0, 2);
        wb(1, ATS_CTRL_ADDR, 32'h41);
        n0 = nfr;
        pulse();
        idle(20);
        chk(nfr - n0, 0);
        // Free run at the fastest rate
        wb(1, ATS_COUNT_ADDR, 1 + $urandom % 4);
        wb(1, ATS_CTRL_ADDR, 32'h40);
        idle(30);
        chk(gap, 2);
        wb(1, ATS_CTRL_ADDR, 32'h4c);
        idle(10);
        n0 = nfr;
        repeat (3) wb(1, ATS_CMD_ADDR, 32'h2);
        idle(5);
        chk(nfr - n0, 3);
        wrap_up();
    end
endmodule
`default_nettype wire
